// >>> rtl/card_window_address_regs.sv
// card socket i/o and memory window address register bank with decode
// ===========================================================
// Summary of operation
// RULE_01 - io start high byte holds address bits 15-8
// RULE_02 - io end low byte holds address bits 7-0
// RULE_03 - io end high byte holds address bits 15-8
// RULE_04 - memory start low byte holds A19 to A12
// RULE_05 - memory start high bits 3-0 hold A23-A20
// RULE_06 - start high bit 7 selects 16-bit width
// RULE_07 - fast bit shrinks 8-bit cycles to three
// RULE_08 - fast bit shrinks 16-bit cycles to two
// RULE_09 - start high bits 5-4 are plain scratch
// RULE_10 - separate copy per socket, second at 40h
// RULE_11 - mapped region at socket base plus 800h
// RULE_12 - memory groups spaced eight bytes apart
// RULE_13 - io window 1 bytes start at 0Ch
// RULE_14 - memory window decodes only while enabled
// RULE_15 - memory end low byte bounds window top
// RULE_16 - io width follows size bit unless auto
// RULE_17 - hit when start <= address <= end
// RULE_18 - registers read back written value except memory end high bits 5-4, reset zero
`timescale 1ns/1ps
`include "card_window_map.svh"

module card_window_address_regs (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [6:0] idx_addr_i,
	input wire logic idx_wr_i,
	input wire logic idx_rd_i,
	input wire card_window_pkg::byte_t idx_wdata_i,
	output card_window_pkg::byte_t idx_rdata_o,
	output logic idx_rvalid_o,
	input wire logic mm_sock_i,
	input wire logic [11:0] mm_addr_i,
	input wire logic mm_wr_i,
	input wire logic mm_rd_i,
	input wire card_window_pkg::byte_t mm_wdata_i,
	output card_window_pkg::byte_t mm_rdata_o,
	output logic mm_rvalid_o,
	input wire logic dec_sock_i,
	input wire logic [11:0] dec_mem_addr_i,
	input wire logic [15:0] dec_io_addr_i,
	input wire logic card_io16_i,
	output logic [4:0] mem_hit_o,
	output logic mem_wide_o,
	output card_window_pkg::cycle_len_t mem_cycle_len_o,
	output logic [1:0] io_hit_o,
	output logic io_wide_o
);
	import card_window_pkg::*;

	window_state_t st_reg;
	window_state_t st_next;

	// ===========================================================
	// register read
	// unimplemented indices inside the socket space read as zero
	function automatic byte_t read_byte(
		input window_state_t s,
		input logic sk,
		input reg_idx_t ix
	);
		byte_t d;
		reg_idx_t rel;
		logic [2:0] w;
		d = `RESET_BYTE;
		rel = ix - `MEM_GROUP_FIRST;
		w = rel[5:3];
		if (ix == `IDX_WIN_ENABLE) begin
			d = s.win_en[sk];
		end else if (ix == `IDX_IO_CONTROL) begin
			d = s.io_ctl[sk];
		end else if (ix >= `IO_GROUP_FIRST && ix <= `IO_GROUP_LAST) begin
			// window number sits in index bit 2 [RULE_13]
			unique case ({1'b0, ix[1:0]})
				`BYTE_START_LOW: d = s.io_start_lo[sk][ix[2]];
				`BYTE_START_HIGH: d = s.io_start_hi[sk][ix[2]];
				`BYTE_END_LOW: d = s.io_end_lo[sk][ix[2]];
				`BYTE_END_HIGH: d = s.io_end_hi[sk][ix[2]];
			endcase
		end else if (ix >= `MEM_GROUP_FIRST && ix <= `MEM_GROUP_LAST) begin
			// eight bytes per group, offset bytes not held here [RULE_12]
			case (rel[2:0])
				`BYTE_START_LOW: d = s.mem_start_lo[sk][w];
				`BYTE_START_HIGH: d = s.mem_start_hi[sk][w];
				`BYTE_END_LOW: d = s.mem_end_lo[sk][w];
				`BYTE_END_HIGH: d = s.mem_end_hi[sk][w];
				default: d = `RESET_BYTE;
			endcase
		end
		return d;
	endfunction

	// ===========================================================
	// register write
	// all eight bits stored as given, scratch bits included, except memory end high bits 5-4 [RULE_18]
	function automatic window_state_t write_byte(
		input window_state_t s,
		input logic sk,
		input reg_idx_t ix,
		input byte_t d
	);
		window_state_t r;
		reg_idx_t rel;
		logic [2:0] w;
		r = s;
		rel = ix - `MEM_GROUP_FIRST;
		w = rel[5:3];
		if (ix == `IDX_WIN_ENABLE) begin
			r.win_en[sk] = d;
		end else if (ix == `IDX_IO_CONTROL) begin
			r.io_ctl[sk] = d;
		end else if (ix >= `IO_GROUP_FIRST && ix <= `IO_GROUP_LAST) begin
			unique case ({1'b0, ix[1:0]})
				`BYTE_START_LOW: r.io_start_lo[sk][ix[2]] = d;
				`BYTE_START_HIGH: r.io_start_hi[sk][ix[2]] = d; // [RULE_01]
				`BYTE_END_LOW: r.io_end_lo[sk][ix[2]] = d; // [RULE_02]
				`BYTE_END_HIGH: r.io_end_hi[sk][ix[2]] = d; // [RULE_03]
			endcase
		end else if (ix >= `MEM_GROUP_FIRST && ix <= `MEM_GROUP_LAST) begin
			case (rel[2:0])
				`BYTE_START_LOW: begin
					r.mem_start_lo[sk][w] = d; // [RULE_04]
				end
				`BYTE_START_HIGH: begin
					// bits 5-4 kept but never read by decode [RULE_09]
					r.mem_start_hi[sk][w] = d; // [RULE_05] [RULE_06]
				end
				`BYTE_END_LOW: begin
					r.mem_end_lo[sk][w] = d; // [RULE_15]
				end
				`BYTE_END_HIGH: begin
					// reserved bits 5-4 never store
					r.mem_end_hi[sk][w] = d & `END_HIGH_MASK;
				end
				default: begin
					r.mem_end_hi[sk][w] = s.mem_end_hi[sk][w];
				end
			endcase
		end
		return r;
	endfunction

	// ===========================================================
	// next state
	always_comb begin
		logic mm_in_region;
		logic [11:0] lo_bound;
		logic [11:0] hi_bound;
		logic [15:0] io_lo;
		logic [15:0] io_hi;
		logic found;
		logic fast;
		logic wide;
		logic src;
		logic size;
		mm_in_region = 1'b0;
		lo_bound = 12'h000;
		hi_bound = 12'h000;
		io_lo = 16'h0000;
		io_hi = 16'h0000;
		found = 1'b0;
		fast = 1'b0;
		wide = 1'b0;
		src = 1'b0;
		size = 1'b0;
		st_next = st_reg;

		// mapped region is 800h..83Fh of the chosen socket [RULE_11]
		mm_in_region = (mm_addr_i[11:6] == `MM_REGION_TAG);

		// read data registered one cycle after the strobe
		st_next.idx_rvalid = idx_rd_i;
		st_next.mm_rvalid = mm_rd_i;
		st_next.idx_rdata = `RESET_BYTE;
		st_next.mm_rdata = `RESET_BYTE;
		if (idx_rd_i) begin
			// index bit 6 picks the second socket copy [RULE_10]
			st_next.idx_rdata = read_byte(st_reg,
				idx_addr_i[`SOCKET_SEL_BIT], idx_addr_i[5:0]);
		end
		if (mm_rd_i && mm_in_region) begin
			st_next.mm_rdata = read_byte(st_reg, mm_sock_i,
				mm_addr_i[5:0]); // [RULE_11]
		end

		// writes: the mapped port lands last, so it wins a collision
		if (idx_wr_i) begin
			st_next = write_byte(st_next, idx_addr_i[`SOCKET_SEL_BIT],
				idx_addr_i[5:0], idx_wdata_i); // [RULE_10]
		end
		if (mm_wr_i && mm_in_region) begin
			st_next = write_byte(st_next, mm_sock_i, mm_addr_i[5:0],
				mm_wdata_i); // [RULE_11]
		end

		// memory window decode; lowest hit window sets cycle style
		st_next.mem_hit = 5'h00;
		for (int n = 0; n < 5; n++) begin
			lo_bound = {st_reg.mem_start_hi[dec_sock_i][n][3:0],
				st_reg.mem_start_lo[dec_sock_i][n]}; // [RULE_05]
			hi_bound = {st_reg.mem_end_hi[dec_sock_i][n][3:0],
				st_reg.mem_end_lo[dec_sock_i][n]}; // [RULE_15]
			if (st_reg.win_en[dec_sock_i][n] // [RULE_14]
				&& dec_mem_addr_i >= lo_bound
				&& dec_mem_addr_i <= hi_bound) begin // [RULE_17]
				st_next.mem_hit[n] = 1'b1;
				if (!found) begin
					found = 1'b1;
					wide = st_reg.mem_start_hi[dec_sock_i][n][`MEM_WIDTH_BIT];
					fast = st_reg.mem_start_hi[dec_sock_i][n][`MEM_FAST_BIT];
				end
			end
		end
		st_next.mem_wide = wide; // [RULE_06]

		// shortened cycles only when the fast bit is set
		if (wide) begin
			st_next.mem_len = fast ? `LEN_FAST_16 : `LEN_STD_16; // [RULE_08]
		end else begin
			st_next.mem_len = fast ? `LEN_FAST_8 : `LEN_STD_8; // [RULE_07]
		end

		// io window decode; width from the first hit window
		st_next.io_hit = 2'h0;
		found = 1'b0;
		for (int w = 0; w < 2; w++) begin
			io_lo = {st_reg.io_start_hi[dec_sock_i][w],
				st_reg.io_start_lo[dec_sock_i][w]}; // [RULE_01]
			io_hi = {st_reg.io_end_hi[dec_sock_i][w],
				st_reg.io_end_lo[dec_sock_i][w]}; // [RULE_02] [RULE_03]
			if (st_reg.win_en[dec_sock_i][`EN_IO_BASE + w]
				&& dec_io_addr_i >= io_lo
				&& dec_io_addr_i <= io_hi) begin // [RULE_17]
				st_next.io_hit[w] = 1'b1;
				if (!found) begin
					found = 1'b1;
					src = st_reg.io_ctl[dec_sock_i][{w[0], 1'b0, `IOCTL_SRC_BIT}];
					size = st_reg.io_ctl[dec_sock_i][{w[0], 1'b0, `IOCTL_SIZE_BIT}];
				end
			end
		end
		// card's own 16-bit signal only when the source bit asks for it
		st_next.io_wide = src ? card_io16_i : size; // [RULE_16]
	end

	// ===========================================================
	// state register
	// whole bank clears to zero on reset [RULE_18]
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ===========================================================
	// outputs straight from the state register
	assign idx_rdata_o = st_reg.idx_rdata;
	assign idx_rvalid_o = st_reg.idx_rvalid;
	assign mm_rdata_o = st_reg.mm_rdata;
	assign mm_rvalid_o = st_reg.mm_rvalid;
	assign mem_hit_o = st_reg.mem_hit;
	assign mem_wide_o = st_reg.mem_wide;
	assign mem_cycle_len_o = st_reg.mem_len;
	assign io_hit_o = st_reg.io_hit;
	assign io_wide_o = st_reg.io_wide;

endmodule

// >>> rtl/card_window_map.svh
// register offsets, field positions and timing figures of the window bank
`ifndef CARD_WINDOW_MAP_SVH
`define CARD_WINDOW_MAP_SVH

// ===========================================================
// register indices inside one socket's legacy space
`define IDX_WIN_ENABLE 6'h06
`define IDX_IO_CONTROL 6'h07
`define IDX_IO_WIN0_START_HIGH 6'h09
`define IDX_IO_WIN0_END_LOW 6'h0A
`define IDX_IO_WIN0_END_HIGH 6'h0B
`define IDX_IO_WIN1_START_HIGH 6'h0D
`define IDX_IO_WIN1_END_LOW 6'h0E
`define IDX_IO_WIN1_END_HIGH 6'h0F
`define IDX_MEM_WIN0_START_LOW 6'h10
`define IDX_MEM_WIN0_START_HIGH 6'h11
`define IDX_MEM_WIN1_START_LOW 6'h18
`define IDX_MEM_WIN1_START_HIGH 6'h19
`define IDX_MEM_WIN2_START_LOW 6'h20
`define IDX_MEM_WIN2_START_HIGH 6'h21
`define IDX_MEM_WIN3_START_LOW 6'h28
`define IDX_MEM_WIN3_START_HIGH 6'h29
`define IDX_MEM_WIN4_START_LOW 6'h30
`define IDX_MEM_WIN4_START_HIGH 6'h31

// ===========================================================
// group layout: io groups are 4 bytes, memory groups 8 bytes
`define IO_GROUP_FIRST 6'h08
`define IO_GROUP_LAST 6'h0F
`define MEM_GROUP_FIRST 6'h10
`define MEM_GROUP_LAST 6'h37
`define BYTE_START_LOW 3'h0
`define BYTE_START_HIGH 3'h1
`define BYTE_END_LOW 3'h2
`define BYTE_END_HIGH 3'h3

// ===========================================================
// socket selection
`define SOCKET_SEL_BIT 6
`define MM_REGION_TAG 6'h20

// ===========================================================
// field positions
`define MEM_WIDTH_BIT 7
`define MEM_FAST_BIT 6
`define END_HIGH_MASK 8'hCF
`define EN_IO_BASE 6
`define IOCTL_SIZE_BIT 1'h0
`define IOCTL_SRC_BIT 1'h1
`define RESET_BYTE 8'h00

// ===========================================================
// memory cycle length in equivalent bus cycles
`define LEN_STD_8 3'h6
`define LEN_STD_16 3'h4
`define LEN_FAST_8 3'h3
`define LEN_FAST_16 3'h2

`endif

// >>> rtl/card_window_pkg.sv
// types shared by the card window register bank
package card_window_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [5:0] reg_idx_t;
	typedef logic [2:0] cycle_len_t;

	// every flip-flop of the bank, two sockets
	typedef struct packed {
		logic [1:0][7:0] win_en;
		logic [1:0][7:0] io_ctl;
		logic [1:0][1:0][7:0] io_start_lo;
		logic [1:0][1:0][7:0] io_start_hi;
		logic [1:0][1:0][7:0] io_end_lo;
		logic [1:0][1:0][7:0] io_end_hi;
		logic [1:0][4:0][7:0] mem_start_lo;
		logic [1:0][4:0][7:0] mem_start_hi;
		logic [1:0][4:0][7:0] mem_end_lo;
		logic [1:0][4:0][7:0] mem_end_hi;
		logic [7:0] idx_rdata;
		logic idx_rvalid;
		logic [7:0] mm_rdata;
		logic mm_rvalid;
		logic [4:0] mem_hit;
		logic mem_wide;
		logic [2:0] mem_len;
		logic [1:0] io_hit;
		logic io_wide;
	} window_state_t;

endpackage

// >>> tb/card_io_model.sv
// behavioural card: answers the 16-bit i/o indication for its own port
`timescale 1ns/1ps
module card_io_model (
	input wire logic [15:0] io_addr_i,
	input wire logic [15:0] wide_port_i,
	output logic card_io16_o
);
	// decoded combinationally like a real card, 8-bit everywhere else
	assign card_io16_o = (io_addr_i == wide_port_i);
endmodule

// >>> tb/card_window_sva.sv
// port-level assertions for the card window register bank
`timescale 1ns/1ps
module card_window_sva (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [6:0] idx_addr_i,
	input wire logic idx_wr_i,
	input wire logic idx_rd_i,
	input wire card_window_pkg::byte_t idx_wdata_i,
	input wire card_window_pkg::byte_t idx_rdata_o,
	input wire logic idx_rvalid_o,
	input wire logic mm_wr_i,
	input wire logic mm_rd_i,
	input wire card_window_pkg::byte_t mm_rdata_o,
	input wire logic mm_rvalid_o,
	input wire logic [4:0] mem_hit_o,
	input wire logic mem_wide_o,
	input wire card_window_pkg::cycle_len_t mem_cycle_len_o,
	input wire logic [1:0] io_hit_o
);
	import card_window_pkg::*;
	// ===========================================================
	// one clock domain, reset masks every check
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_rd_ans; idx_rd_i |=> idx_rvalid_o; endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("index read got no valid pulse");
	property p_rd_idle;
		!idx_rd_i |=> !idx_rvalid_o && idx_rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("index read data outlived its cycle");
	property p_mm_ans; mm_rd_i |=> mm_rvalid_o; endproperty
	a_mm_ans: assert property (p_mm_ans)
		else $error("mapped read got no valid pulse");
	property p_mm_idle;
		!mm_rd_i |=> !mm_rvalid_o && mm_rdata_o == 8'h00;
	endproperty
	a_mm_idle: assert property (p_mm_idle)
		else $error("mapped read data outlived its cycle");
	// back-to-back write then read of one start low byte
	property p_wr_rd;
		idx_rd_i && $past(idx_wr_i) && !$past(mm_wr_i) &&
		idx_addr_i[5:0] == 6'h10 && $past(idx_addr_i) == idx_addr_i
		|=> idx_rdata_o == $past(idx_wdata_i, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd)
		else $error("start low byte did not read back");
	property p_len8;
		mem_hit_o != 5'h00 && !mem_wide_o |->
		mem_cycle_len_o inside {3'h6, 3'h3};
	endproperty
	a_len8: assert property (p_len8)
		else $error("8-bit cycle length wrong");
	property p_len16; mem_wide_o |-> mem_cycle_len_o inside {3'h4, 3'h2};
	endproperty
	a_len16: assert property (p_len16)
		else $error("16-bit cycle length wrong");
	property p_wide_hit; mem_wide_o |-> mem_hit_o != 5'h00; endproperty
	a_wide_hit: assert property (p_wide_hit)
		else $error("width shown with no window hit");
	property p_len_idle;
		mem_hit_o == 5'h00 && !$past(rst_i) |-> mem_cycle_len_o == 3'h6;
	endproperty
	a_len_idle: assert property (p_len_idle)
		else $error("idle cycle length wrong");
	// windows come out of reset disabled, so nothing may hit
	property p_rst_quiet;
		$past(rst_i) |-> mem_hit_o == 5'h00 ##1
		mem_hit_o == 5'h00 && io_hit_o == 2'h0;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("window hit straight after reset");
	c_fast16: cover property (mem_wide_o && mem_cycle_len_o == 3'h2);
	c_io_hit: cover property (io_hit_o != 2'h0);
	c_wr_rd: cover property (idx_wr_i ##1 idx_rd_i ##1 idx_rvalid_o);
endmodule

bind card_window_address_regs card_window_sva u_sva (.clk_sys_i, .rst_i,
	.idx_addr_i, .idx_wr_i, .idx_rd_i, .idx_wdata_i, .idx_rdata_o,
	.idx_rvalid_o, .mm_wr_i, .mm_rd_i, .mm_rdata_o, .mm_rvalid_o,
	.mem_hit_o, .mem_wide_o, .mem_cycle_len_o, .io_hit_o);

// >>> tb/tb.sv
// self-checking bench for the card window register bank
`timescale 1ns/1ps
module tb;
	import card_window_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [6:0] idx_addr_i = 7'h00;
	logic idx_wr_i = 1'b0;
	logic idx_rd_i = 1'b0;
	byte_t idx_wdata_i = 8'h00;
	byte_t idx_rdata_o;
	logic idx_rvalid_o;
	logic mm_sock_i = 1'b0;
	logic [11:0] mm_addr_i = 12'h000;
	logic mm_wr_i = 1'b0;
	logic mm_rd_i = 1'b0;
	byte_t mm_wdata_i = 8'h00;
	byte_t mm_rdata_o;
	logic mm_rvalid_o;
	logic dec_sock_i = 1'b0;
	logic [11:0] dec_mem_addr_i = 12'h000;
	logic [15:0] dec_io_addr_i = 16'h0000;
	logic [15:0] wide_port = 16'h1200;
	logic card_io16_i;
	logic [4:0] mem_hit_o;
	logic mem_wide_o;
	cycle_len_t mem_cycle_len_o;
	logic [1:0] io_hit_o;
	logic io_wide_o;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [5:0] offs [16] = '{6'h09, 6'h0A, 6'h0B, 6'h0D, 6'h0E, 6'h0F,
		6'h10, 6'h11, 6'h18, 6'h19, 6'h20, 6'h21, 6'h28, 6'h29, 6'h30, 6'h31};

	card_window_address_regs u_dut (.clk_sys_i, .rst_i, .idx_addr_i,
		.idx_wr_i, .idx_rd_i, .idx_wdata_i, .idx_rdata_o, .idx_rvalid_o,
		.mm_sock_i, .mm_addr_i, .mm_wr_i, .mm_rd_i, .mm_wdata_i, .mm_rdata_o,
		.mm_rvalid_o, .dec_sock_i, .dec_mem_addr_i, .dec_io_addr_i,
		.card_io16_i, .mem_hit_o, .mem_wide_o, .mem_cycle_len_o, .io_hit_o,
		.io_wide_o);
	card_io_model u_card (.io_addr_i(dec_io_addr_i), .wide_port_i(wide_port),
		.card_io16_o(card_io16_i));

	// ===========================================================
	// clock and hang guard, ceiling well above the ~280 cycles used
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			summarize();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	// strobe rises on a falling edge; hold lets a read follow at once
	task automatic wr(input logic mm, input logic [6:0] a, input byte_t d,
		input logic hold);
		{mm_sock_i, mm_addr_i, mm_wdata_i} = {a[6], 6'h20, a[5:0], d};
		{idx_addr_i, idx_wdata_i} = {a, d};
		if (mm) mm_wr_i = 1'b1;
		else idx_wr_i = 1'b1;
		@(negedge clk_sys_i);
		{mm_wr_i, idx_wr_i} = 2'b00;
		if (!hold) @(negedge clk_sys_i);
	endtask
	task automatic rd(input logic mm, input logic [6:0] a, input byte_t exp);
		{mm_sock_i, mm_addr_i, idx_addr_i} = {a[6], 6'h20, a[5:0], a};
		if (mm) mm_rd_i = 1'b1;
		else idx_rd_i = 1'b1;
		@(negedge clk_sys_i);
		{mm_rd_i, idx_rd_i} = 2'b00;
		chk("read valid", 1'b1, mm ? mm_rvalid_o : idx_rvalid_o);
		chk("read data", exp, mm ? mm_rdata_o : idx_rdata_o);
		@(negedge clk_sys_i);
		chk("idle data", 8'h00, mm ? mm_rdata_o : idx_rdata_o);
	endtask
	task automatic dec(input logic [11:0] ma, input logic [15:0] ia,
		input logic [4:0] hit, input logic wide, input cycle_len_t len,
		input logic [1:0] ihit, input logic iwide);
		{dec_mem_addr_i, dec_io_addr_i} = {ma, ia};
		@(negedge clk_sys_i);
		chk("mem hit", hit, mem_hit_o);
		chk("mem width", wide, mem_wide_o);
		chk("cycle length", len, mem_cycle_len_o);
		chk("io hit", ihit, io_hit_o);
		chk("io width", iwide, io_wide_o);
	endtask

	// ===========================================================
	// scenarios
	task automatic t_reset;
		for (int i = 0; i < 16; i++) begin
			rd(0, {1'b0, offs[i]}, 8'h00);
			rd(1, {1'b1, offs[i]}, 8'h00);
		end
		wr(0, 7'h3F, 8'hA5, 1);
		rd(0, 7'h3F, 8'h00);
		$display("test reset values done");
	endtask
	// socket a through the index port, socket b through the mapped port
	task automatic t_regs;
		for (int i = 0; i < 16; i++) begin
			wr(0, {1'b0, offs[i]}, {offs[i], 2'b10}, 1);
			rd(0, {1'b0, offs[i]}, {offs[i], 2'b10});
		end
		for (int i = 0; i < 16; i++) wr(1, {1'b1, offs[i]}, ~{offs[i], 2'b10}, 0);
		for (int i = 0; i < 16; i++) begin
			rd(1, {1'b0, offs[i]}, {offs[i], 2'b10});
			rd(0, {1'b1, offs[i]}, ~{offs[i], 2'b10});
		end
		$display("test register access done");
	endtask
	task automatic t_mem;
		wr(0, 7'h06, 8'h01, 0);
		wr(0, 7'h10, 8'h00, 0);
		wr(0, 7'h12, 8'h0F, 0);
		wr(0, 7'h13, 8'h00, 0);
		wr(0, 7'h11, 8'h80, 0);
		dec(12'h005, 16'h0000, 5'h01, 1'b1, 3'h4, 2'h0, 1'b0);
		wr(0, 7'h11, 8'hC0, 0);
		dec(12'h00F, 16'h0000, 5'h01, 1'b1, 3'h2, 2'h0, 1'b0);
		wr(0, 7'h11, 8'h40, 0);
		dec(12'h000, 16'h0000, 5'h01, 1'b0, 3'h3, 2'h0, 1'b0);
		wr(0, 7'h11, 8'h30, 0);
		dec(12'h005, 16'h0000, 5'h01, 1'b0, 3'h6, 2'h0, 1'b0);
		dec(12'h010, 16'h0000, 5'h00, 1'b0, 3'h6, 2'h0, 1'b0);
		wr(0, 7'h11, 8'h01, 0);
		dec(12'h005, 16'h0000, 5'h00, 1'b0, 3'h6, 2'h0, 1'b0);
		wr(0, 7'h13, 8'h01, 0);
		dec(12'h100, 16'h0000, 5'h01, 1'b0, 3'h6, 2'h0, 1'b0);
		wr(0, 7'h06, 8'h00, 0);
		dec(12'h100, 16'h0000, 5'h00, 1'b0, 3'h6, 2'h0, 1'b0);
		$display("test memory decode done");
	endtask
	task automatic t_io;
		wr(0, 7'h08, 8'h00, 0);
		wr(0, 7'h09, 8'h12, 0);
		wr(0, 7'h0A, 8'hFF, 0);
		wr(0, 7'h0B, 8'h12, 0);
		wr(0, 7'h07, 8'h00, 0);
		wr(0, 7'h06, 8'h40, 0);
		dec(12'h000, 16'h1200, 5'h00, 1'b0, 3'h6, 2'h1, 1'b0);
		dec(12'h000, 16'h12FF, 5'h00, 1'b0, 3'h6, 2'h1, 1'b0);
		dec(12'h000, 16'h1300, 5'h00, 1'b0, 3'h6, 2'h0, 1'b0);
		dec(12'h000, 16'h11FF, 5'h00, 1'b0, 3'h6, 2'h0, 1'b0);
		wr(0, 7'h07, 8'h01, 0);
		dec(12'h000, 16'h1234, 5'h00, 1'b0, 3'h6, 2'h1, 1'b1);
		wr(0, 7'h07, 8'h03, 0);
		dec(12'h000, 16'h1200, 5'h00, 1'b0, 3'h6, 2'h1, 1'b1);
		dec(12'h000, 16'h1201, 5'h00, 1'b0, 3'h6, 2'h1, 1'b0);
		$display("test io decode done");
	endtask
	// socket b windows decode only for socket b lookups
	task automatic t_sock;
		wr(0, 7'h52, 8'hFF, 0);
		wr(0, 7'h53, 8'hFF, 1);
		rd(0, 7'h53, 8'hCF);
		wr(1, 7'h46, 8'h01, 0);
		dec(12'hFFF, 16'h0000, 5'h00, 1'b0, 3'h6, 2'h0, 1'b0);
		dec_sock_i = 1'b1;
		dec(12'hFFF, 16'h0000, 5'h01, 1'b1, 3'h4, 2'h0, 1'b0);
		dec_sock_i = 1'b0;
		$display("test socket decode done");
	endtask

	task automatic summarize;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		t_reset();
		t_regs();
		t_mem();
		t_io();
		t_sock();
		summarize();
	end
endmodule
